//--- logic/asi_pkg.sv
package asi_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_STATUS = 8'h00; // flag_register
  localparam logic [7:0] OFS_DATA   = 8'h04; // data_port_reg
  localparam logic [7:0] OFS_CTRL1  = 8'h08; // ctrl_reg_one
  localparam logic [7:0] OFS_CTRL2  = 8'h0C; // ctrl_reg_two
  localparam logic [7:0] OFS_BAUD   = 8'h10; // baud_sel_reg
  localparam logic [7:0] OFS_TXPRE  = 8'h14; // tx_fine_prescaler
  localparam logic [7:0] OFS_RXPRE  = 8'h18; // rx_fine_prescaler
  // ctrl_reg_one fields
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_W9  = 4;
  // ctrl_reg_two fields
  localparam int C2_TIE  = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_LINE_IRQ_EN = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_MUTE = 1;
  localparam int C2_SBK  = 0;
  // baud_sel_reg fields: coarse [7:6], tx power [5:3], rx power [2:0]
  localparam int BD_PR = 6;
  localparam int BD_TR = 3;
  localparam int BD_RR = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  // timing: 16 samples per bit, centre samples 7..9
  localparam int CLK_HZ   = 50_000_000;
  localparam int MAX_BAUD = 250_000;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_LAST  = 4'h9;
  localparam logic [3:0] BITS8 = 4'hA; // start + 8 + stop
  localparam logic [3:0] BITS9 = 4'hB; // start + 9 + stop
  // status flags, bit order as read from flag_register [7:1]
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tc;
    logic rx_full;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
  } asi_flags_s;
  localparam asi_flags_s FLAGS_RST = 7'h60; // tx_buffer_empty_flag and tc set
endpackage : asi_pkg

//--- logic/asi_top.sv
module asi_top (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // serial pins
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_en,
  // cpu interrupt
  input  wire logic       cpu_irq_mask,
  output logic            irq
);
  typedef enum logic [3:0] {
    TX_OFF = 4'h1, TX_READY = 4'h2, TX_SHIFT = 4'h4, TX_SPARE = 4'h8
  } asi_tx_e;
  typedef enum logic [2:0] {
    RX_OFF = 3'h1, RX_HUNT = 3'h2, RX_BITS = 3'h4
  } asi_rx_e;
  typedef enum logic [1:0] {
    K_DATA = 2'h0, K_IDLE = 2'h1, K_BRK = 2'h2, K_MARK = 2'h3
  } asi_kind_e;

  // 16x tick divisor: fine value, else 2*coarse*2^pow
  function automatic logic [11:0] baud_div(input logic [7:0] fine,
                                           input logic [1:0] pr,
                                           input logic [2:0] pow);
    logic [11:0] c;
    c = (pr == 2'h0) ? 12'h002 : (pr == 2'h1) ? 12'h006 :
        (pr == 2'h2) ? 12'h008 : 12'h01A;
    baud_div = (fine != 8'h00) ? {4'h0, fine} : 12'(c << pow);
  endfunction : baud_div

  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  logic [7:0]        ctrl1_q, ctrl2_q, baud_q, txpre_q, rxpre_q; // control registers
  logic              seq_armed_q;         // status was read
  asi_pkg::asi_flags_s flags_q;          // sticky status
  logic [7:0]        rx_hold_q;           // rx_holding_buf
  logic              rx9_q;               // rx_ninth_bit
  logic [7:0]        tx_hold_q;           // tx_holding_buf
  logic              tx_hold9_q;
  logic              hold_v_q;            // holding buffer full
  logic              te_prev_q, pend_idle_q, last_brk_q;
  asi_tx_e           tx_st_q;
  asi_kind_e         kind_q;
  logic [10:0]       tx_sh_q;             // frame shifter, bit 0 on the line
  logic [3:0]        tx_cnt_q, tx_bits_q;
  logic              tx_load_q, tx_done_q; // one-cycle events
  asi_rx_e           rx_st_q;
  logic [3:0]        rx_cnt_q, rx_idx_q;
  logic [2:0]        smp_q;
  logic [8:0]        rx_sh_q;
  logic              rx_noise_q;
  logic [7:0]        idle_cnt_q;
  logic              idle_arm_q;
  logic              rx_done_q, rx_fe_q, rx_nf_q, rx_idle_q;
  logic [7:0]        rx_data_q;
  logic              rx_d9_q;
  logic [1:0]        tick;                // 0 tx, 1 rx
  logic              acc, rd_st, dat_rd, dat_wr, w9, te, re, rbit;
  logic [3:0]        frame_bits;

  assign acc = psel & penable & pready;
  assign rd_st = acc & ~pwrite & (paddr == asi_pkg::OFS_STATUS);
  assign dat_rd = acc & ~pwrite & (paddr == asi_pkg::OFS_DATA);
  assign dat_wr = acc & pwrite & (paddr == asi_pkg::OFS_DATA);
  assign w9 = ctrl1_q[asi_pkg::C1_W9];
  assign te = ctrl2_q[asi_pkg::C2_TE];
  assign re = ctrl2_q[asi_pkg::C2_RE];
  assign frame_bits = w9 ? asi_pkg::BITS9 : asi_pkg::BITS8;
  assign rbit = maj3(smp_q);

  // apb: one wait state, read data and error latched with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
        case (paddr)
          asi_pkg::OFS_STATUS: prdata[7:1] <= flags_q;
          asi_pkg::OFS_DATA:   prdata[7:0] <= rx_hold_q;
          asi_pkg::OFS_CTRL1:  prdata[7:0] <= {rx9_q, ctrl1_q[6:0]};
          asi_pkg::OFS_CTRL2:  prdata[7:0] <= ctrl2_q;
          asi_pkg::OFS_BAUD:   prdata[7:0] <= baud_q;
          asi_pkg::OFS_TXPRE:  prdata[7:0] <= txpre_q;
          asi_pkg::OFS_RXPRE:  prdata[7:0] <= rxpre_q;
          default:             pslverr <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_q <= asi_pkg::CTRL_RST;
      ctrl2_q <= asi_pkg::CTRL_RST;
      baud_q  <= asi_pkg::CTRL_RST;
      txpre_q <= asi_pkg::CTRL_RST;
      rxpre_q <= asi_pkg::CTRL_RST;
    end
    else if (acc & pwrite)
    begin
      case (paddr)
        asi_pkg::OFS_CTRL1: ctrl1_q <= pwdata[7:0];
        asi_pkg::OFS_CTRL2: ctrl2_q <= pwdata[7:0];
        // rates are not meant to move while either side runs
        asi_pkg::OFS_BAUD:  baud_q  <= pwdata[7:0];
        asi_pkg::OFS_TXPRE: txpre_q <= pwdata[7:0];
        asi_pkg::OFS_RXPRE: rxpre_q <= pwdata[7:0];
        default:            ctrl1_q <= ctrl1_q;
      endcase
    end
  end

  // two independent 16x tick dividers
  for (genvar g = 0; g < 2; g++)
  begin : g_baud
    logic [11:0] cnt_q;
    logic [11:0] div;
    assign div = (g == 0) ? baud_div(txpre_q, baud_q[asi_pkg::BD_PR +: 2],
                                     baud_q[asi_pkg::BD_TR +: 3])
                          : baud_div(rxpre_q, baud_q[asi_pkg::BD_PR +: 2],
                                     baud_q[asi_pkg::BD_RR +: 3]);
    assign tick[g] = (cnt_q == 12'h001) | (cnt_q == 12'h000);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt_q <= 12'h000;
      else if (tick[g])
        cnt_q <= div;
      else
        cnt_q <= cnt_q - 12'h001;
    end
  end

  // status-read then data-access sequence tracker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_armed_q <= 1'b0;
    else if (rd_st)
      seq_armed_q <= 1'b1;
    else if (dat_rd | dat_wr)
      seq_armed_q <= 1'b0;
  end

  // transmitter: holding buffer, frame chooser, shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q     <= TX_OFF;
      kind_q      <= K_DATA;
      tx_sh_q     <= 11'h7FF;
      tx_cnt_q    <= 4'h0;
      tx_bits_q   <= 4'h0;
      hold_v_q    <= 1'b0;
      tx_hold_q   <= 8'h00;
      tx_hold9_q  <= 1'b0;
      te_prev_q   <= 1'b0;
      pend_idle_q <= 1'b0;
      last_brk_q  <= 1'b0;
      tx_load_q   <= 1'b0;
      tx_done_q   <= 1'b0;
    end
    else
    begin
      tx_load_q <= 1'b0;
      tx_done_q <= 1'b0;
      te_prev_q <= te;
      if (te & ~te_prev_q)
        pend_idle_q <= 1'b1;
      if (dat_wr)
      begin
        // always lands in the holding buffer; an idle shifter takes it next cycle
        tx_hold_q  <= pwdata[7:0];
        tx_hold9_q <= ctrl1_q[asi_pkg::C1_TX9];
        hold_v_q   <= 1'b1;
      end
      case (tx_st_q)
        TX_OFF:
        begin
          if (te)
            tx_st_q <= TX_READY;
        end
        TX_READY:
        begin
          tx_cnt_q <= 4'h0;
          tx_bits_q <= frame_bits;
          if (!te)
            tx_st_q <= TX_OFF;
          else if (pend_idle_q)
          begin
            // preamble; whatever waited in the buffer is dropped
            pend_idle_q <= 1'b0;
            hold_v_q    <= dat_wr;
            kind_q      <= K_IDLE;
            tx_sh_q     <= 11'h7FF;
            tx_st_q     <= TX_SHIFT;
          end
          else if (ctrl2_q[asi_pkg::C2_SBK])
          begin
            kind_q     <= K_BRK;
            last_brk_q <= 1'b1;
            tx_sh_q    <= 11'h000;
            tx_st_q    <= TX_SHIFT;
          end
          else if (last_brk_q)
          begin
            // single high bit after the last break frame
            last_brk_q <= 1'b0;
            kind_q     <= K_MARK;
            tx_bits_q  <= 4'h1;
            tx_sh_q    <= 11'h7FF;
            tx_st_q    <= TX_SHIFT;
          end
          else if (hold_v_q)
          begin
            hold_v_q  <= dat_wr;
            tx_load_q <= 1'b1;
            kind_q    <= K_DATA;
            tx_sh_q   <= w9 ? {1'b1, tx_hold9_q, tx_hold_q, 1'b0}
                            : {2'b11, tx_hold_q, 1'b0};
            tx_st_q   <= TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          if (tick[0])
          begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == asi_pkg::OVS_LAST)
            begin
              tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_bits_q == 4'h1)
              begin
                tx_done_q <= (kind_q != K_MARK);
                tx_st_q   <= TX_READY;
              end
            end
          end
        end
        default: tx_st_q <= TX_OFF;
      endcase
    end
  end

  // receiver: hunt, centre-sample, assemble, idle watch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q    <= RX_OFF;
      rx_cnt_q   <= 4'h0;
      rx_idx_q   <= 4'h0;
      smp_q      <= 3'h7;
      rx_sh_q    <= 9'h000;
      rx_noise_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      idle_arm_q <= 1'b0;
      rx_done_q  <= 1'b0;
      rx_fe_q    <= 1'b0;
      rx_nf_q    <= 1'b0;
      rx_idle_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_d9_q    <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      rx_idle_q <= 1'b0;
      if (!re)
        rx_st_q <= RX_OFF;
      else
      case (rx_st_q)
        RX_OFF:
        begin
          idle_cnt_q <= 8'h00;
          idle_arm_q <= 1'b0;
          rx_st_q    <= RX_HUNT;
        end
        RX_HUNT:
        begin
          rx_cnt_q   <= 4'h0;
          rx_idx_q   <= 4'h0;
          rx_noise_q <= 1'b0;
          if (tick[1] & ~serial_in_pin)
          begin
            idle_cnt_q <= 8'h00;
            rx_cnt_q   <= 4'h1;
            rx_st_q    <= RX_BITS;
          end
          else if (tick[1] & (idle_cnt_q == {frame_bits, 4'h0}))
          begin
            // one whole frame of ones; flag once per character
            idle_cnt_q <= 8'h00;
            idle_arm_q <= 1'b0;
            rx_idle_q  <= idle_arm_q;
          end
          else if (tick[1])
            idle_cnt_q <= idle_cnt_q + 8'h01;
        end
        RX_BITS:
        begin
          if (tick[1])
          begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q >= asi_pkg::SMP_FIRST && rx_cnt_q <= asi_pkg::SMP_LAST)
              smp_q <= {serial_in_pin, smp_q[2:1]};
            if (rx_cnt_q == asi_pkg::OVS_LAST)
            begin
              rx_idx_q <= rx_idx_q + 4'h1;
              if ((smp_q != 3'h0) && (smp_q != 3'h7))
                rx_noise_q <= 1'b1;
              if (rx_idx_q == 4'h0 && rbit)
                rx_st_q <= RX_HUNT; // false start
              else if (rx_idx_q == frame_bits - 4'h1)
              begin
                rx_done_q  <= 1'b1;
                rx_fe_q    <= ~rbit;
                rx_nf_q    <= rx_noise_q | ((smp_q != 3'h0) && (smp_q != 3'h7));
                rx_data_q  <= w9 ? rx_sh_q[7:0] : rx_sh_q[8:1];
                rx_d9_q    <= w9 & rx_sh_q[8];
                idle_arm_q <= 1'b1;
                rx_st_q    <= RX_HUNT;
              end
              else if (rx_idx_q != 4'h0)
                rx_sh_q <= {rbit, rx_sh_q[8:1]};
            end
          end
        end
        default: rx_st_q <= RX_OFF;
      endcase
    end
  end

  // receive holding buffer; kept when overrun
  // a clearing data read in the same cycle frees it, so the new word lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_hold_q <= 8'h00;
      rx9_q     <= 1'b0;
    end
    else if (rx_done_q & (~flags_q.rx_full | (dat_rd & seq_armed_q)))
    begin
      rx_hold_q <= rx_data_q;
      rx9_q     <= rx_d9_q;
    end
  end

  // sticky flags: clears first, hardware sets win
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= asi_pkg::FLAGS_RST;
    else
    begin
      if (dat_wr & seq_armed_q)
      begin
        flags_q.tx_buffer_empty_flag <= 1'b0;
        flags_q.tc   <= 1'b0;
      end
      if ((dat_rd & seq_armed_q) | ~re)
      begin
        flags_q.rx_full <= 1'b0;
        flags_q.idle    <= 1'b0;
        flags_q.ovr     <= 1'b0;
        flags_q.nf      <= 1'b0;
        flags_q.fe      <= 1'b0;
      end
      if (tx_load_q)
        flags_q.tx_buffer_empty_flag <= 1'b1;
      if (tx_done_q)
        flags_q.tc <= 1'b1;
      if (re & rx_done_q & flags_q.rx_full & ~(dat_rd & seq_armed_q))
        flags_q.ovr <= 1'b1;
      else if (re & rx_done_q)
      begin
        flags_q.rx_full <= 1'b1;
        flags_q.nf      <= rx_nf_q;
        flags_q.fe      <= rx_fe_q;
      end
      if (re & rx_idle_q)
        flags_q.idle <= 1'b1;
    end
  end

  // pin and interrupt outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_out_pin <= 1'b1;
      serial_out_en  <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      serial_out_en  <= (tx_st_q != TX_OFF);
      serial_out_pin <= (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
      irq <= ~cpu_irq_mask & (
             (flags_q.tx_buffer_empty_flag & ctrl2_q[asi_pkg::C2_TIE]) |
             (flags_q.tc & ctrl2_q[asi_pkg::C2_TX_DONE_IRQ_EN]) |
             ((flags_q.rx_full | flags_q.ovr) & ctrl2_q[asi_pkg::C2_RIE]) |
             (flags_q.idle & ctrl2_q[asi_pkg::C2_IDLE_LINE_IRQ_EN]));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pin_idle_high_a: assert property ((tx_st_q == TX_READY) |=>
    (serial_out_pin && serial_out_en)) else $error("idle line not high");
  start_bit_low_a: assert property (tx_load_q |=> serial_out_pin == 1'b0)
    else $error("start bit not low");
  tc_set_a: assert property (tx_done_q |=> flags_q.tc)
    else $error("complete flag not set");
  tx_buffer_empty_flag_set_a: assert property (tx_load_q |=> flags_q.tx_buffer_empty_flag)
    else $error("empty flag not set on load");
  overrun_keep_a: assert property ((re && rx_done_q && flags_q.rx_full
    && !(dat_rd && seq_armed_q)) |=> (flags_q.ovr && $stable(rx_hold_q)))
    else $error("overrun mishandled");
  rx_full_set_a: assert property ((re && rx_done_q && !flags_q.rx_full)
    |=> (flags_q.rx_full && rx_hold_q == $past(rx_data_q)))
    else $error("receive buffer not filled");
  mask_gate_a: assert property (cpu_irq_mask |=> !irq)
    else $error("masked interrupt raised");
  rx_clear_a: assert property ((dat_rd && seq_armed_q && !rx_done_q)
    |=> !flags_q.rx_full && !flags_q.ovr) else $error("receive flags not cleared");
  seq_clear_tx_a: assert property ((dat_wr && seq_armed_q && !tx_load_q && !tx_done_q)
    |=> !flags_q.tc) else $error("complete flag not cleared");
  tx_off_a: assert property ((!te && tx_st_q != TX_SHIFT) |=>
    (tx_st_q == TX_OFF) ##1 !serial_out_en) else $error("transmitter not released");

  frame_cv: cover property (tx_done_q && kind_q == K_DATA);
  break_cv: cover property (tx_done_q && kind_q == K_BRK);
  overrun_cv: cover property (rx_done_q && flags_q.rx_full);
  idle_cv: cover property (rx_idle_q);
endmodule : asi_top

//--- tb/asi_far_end.sv
// far-end serial equipment: frames towards the design, capture of its output
module asi_far_end #(
  parameter int BITC = 16 // clocks per bit at fine prescaler one
) (
  // clock
  input  wire logic pclk,
  // transmit side of the design
  input  wire logic from_dut,
  input  wire logic from_dut_en,
  // receive side of the design
  output logic      to_dut,
  // word length in use
  input  wire logic nine
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] got[$]; // stop level then data, one entry per frame
  logic [8:0] sh;     // capture shifter

  // mark level between frames, a plain idle line
  initial to_dut = 1'b1;

  // capture: find start edge, check it at mid-bit, then sample each bit centre
  always
  begin
    @(negedge from_dut);
    repeat (BITC / 2) @(posedge pclk);
    if (from_dut_en === 1'b1 && from_dut === 1'b0)
    begin
      sh = 9'h000;
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
        repeat (BITC) @(posedge pclk);
        sh[i] = from_dut;
      end
      repeat (BITC) @(posedge pclk);
      got.push_back({from_dut, sh});
    end
  end

  // one frame, lsb first; a low stop level makes a break or framing fault
  task automatic send(input logic [8:0] d, input logic stop);
    @(posedge pclk);
    to_dut <= 1'b0;
    repeat (BITC) @(posedge pclk);
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      to_dut <= d[i];
      repeat (BITC) @(posedge pclk);
    end
    to_dut <= stop;
    repeat (BITC) @(posedge pclk);
    to_dut <= 1'b1;
  endtask : send
endmodule : asi_far_end

//--- tb/tb.sv
// self-checking bench for the serial interface
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, cpu_irq_mask, nine;
  logic [7:0]  paddr;        // apb address
  logic [31:0] pwdata;       // apb write data
  wire  [31:0] prdata;       // apb read data
  wire         pready, pslverr, serial_in_pin, serial_out_pin, serial_out_en, irq;
  int          err_count, n_tests, seed, cnt;
  logic [31:0] r, st;        // read data, status copy
  logic        serr;         // last pslverr
  logic [7:0]  b[8];         // random payloads

  asi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_en(serial_out_en), .cpu_irq_mask(cpu_irq_mask), .irq(irq));
  asi_far_end #(.BITC(16)) far (.pclk(pclk), .from_dut(serial_out_pin),
    .from_dut_en(serial_out_en), .to_dut(serial_in_pin), .nine(nine));

  // 50 mhz clock
  always #10 pclk = ~pclk;

  // expected capture: stop high, ninth bit zero in byte mode
  function automatic logic [31:0] frame_exp(input logic [8:0] d, input logic w9);
    return {22'h0, 1'b1, w9 ? d : {1'b0, d[7:0]}};
  endfunction : frame_exp

  // comparison and mismatch report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  // no wait limit of its own: only the watchdog ends a hung access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll status until all bits of m are set, bounded
  task automatic wait_flag(input logic [7:0] m);
    int n;
    n = 0;
    st = 0;
    while ((st[7:0] & m) !== m && n < 200)
    begin
      apb(1'b0, asi_pkg::OFS_STATUS, 0);
      st = r;
      n++;
    end
    if (n >= 200)
    begin
      err_count++;
      test_done();
    end
  endtask : wait_flag

  // wait until the far end holds k frames, bounded
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (far.got.size() < k && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
    begin
      err_count++;
      test_done();
    end
  endtask : wait_got

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // watchdog, well beyond the expected run of under ten thousand cycles
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_count++;
    test_done();
  end

  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_irq_mask, nine} = 2'b10;
    seed = 32'h63ad;
    foreach (b[i]) b[i] = 8'($random(seed));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    chk(r, 32'hC0);
    chk(serial_out_en, 0);
    apb(1'b0, 8'h40, 0);
    chk(serr, 1);
    // rates set only while both directions are off
    apb(1'b1, asi_pkg::OFS_TXPRE, 1);
    apb(1'b1, asi_pkg::OFS_RXPRE, 1);
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'h2C);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    apb(1'b1, asi_pkg::OFS_DATA, b[0]);
    for (cnt = 0; serial_out_pin === 1'b1 && cnt < 1000; cnt++) @(posedge pclk);
    chk(serial_out_en, 1);
    chk(cnt >= 150, 1);
    apb(1'b1, asi_pkg::OFS_DATA, b[1]);
    wait_got(2);
    chk(far.got[0], frame_exp(b[0], 0));
    chk(far.got[1], frame_exp(b[1], 0));
    wait_flag(8'h40);
    chk(serial_out_pin, 1);
    chk(st[7:6], 2'b11);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    apb(1'b1, asi_pkg::OFS_DATA, b[2]);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    chk(r[6], 0);
    wait_got(3);
    chk(far.got[2], frame_exp(b[2], 0));
    // receive with the request first masked, then unmasked
    far.send(b[3], 1'b1);
    wait_flag(8'h20);
    chk(irq, 0);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    apb(1'b0, asi_pkg::OFS_DATA, 0);
    chk(r, b[3]);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    chk(r & 32'h20, 0);
    chk(irq, 0);
    // two characters unread: second one is an overrun
    far.send(b[4], 1'b1);
    far.send(b[5], 1'b1);
    wait_flag(8'h28);
    chk(st & 32'h28, 32'h28);
    apb(1'b0, asi_pkg::OFS_DATA, 0);
    chk(r, b[4]);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    chk(r & 32'h28, 0);
    // incoming break: framing error with data moved
    far.send(9'h000, 1'b0);
    wait_flag(8'h22);
    chk(st & 32'h22, 32'h22);
    apb(1'b0, asi_pkg::OFS_DATA, 0);
    chk(r, 0);
    // nine-bit words both ways
    nine <= 1'b1;
    apb(1'b1, asi_pkg::OFS_CTRL1, 32'h50);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    apb(1'b1, asi_pkg::OFS_DATA, b[6]);
    wait_got(4);
    chk(far.got[3], frame_exp({1'b1, b[6]}, 1));
    far.send({1'b1, b[7]}, 1'b1);
    wait_flag(8'h20);
    apb(1'b0, asi_pkg::OFS_CTRL1, 0);
    chk(r[7], 1);
    apb(1'b0, asi_pkg::OFS_DATA, 0);
    chk(r, b[7]);
    // outgoing break: line low for at least 380 of 400 clocks across frames, high again after clearing
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'h2D);
    repeat (40) @(posedge pclk);
    cnt = 0;
    repeat (400) @(posedge pclk) cnt += (serial_out_pin === 1'b0);
    chk(cnt >= 380, 1);
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'h2C);
    repeat (400) @(posedge pclk);
    chk(serial_out_pin, 1);
    // empty-buffer request once its enable is set, mask already open
    chk(irq, 0);
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'hAC);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    // conventional divider, coarse one and power zero: 32 clocks a bit,
    // less up to one tick of divider phase at the start bit
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'h00);
    apb(1'b1, asi_pkg::OFS_TXPRE, 0);
    apb(1'b1, asi_pkg::OFS_CTRL2, 32'h08);
    apb(1'b0, asi_pkg::OFS_STATUS, 0);
    apb(1'b1, asi_pkg::OFS_DATA, 1);
    for (cnt = 0; serial_out_pin === 1'b1 && cnt < 2000; cnt++) @(posedge pclk);
    for (cnt = 0; serial_out_pin === 1'b0 && cnt < 100; cnt++) @(posedge pclk);
    chk(cnt >= 31 && cnt <= 32, 1);
    test_done();
  end
endmodule : tb
